// >>> iba_ctrl.sv
// iba_ctrl: internal bus arbiter, write buffer control, clock enables.
// assumes cpu and dma masters on ref_clk; control port driven by
// the peripheral bus logic on the same clock.
// Functional notes
// - arbitrate cpu and dma; dma wins a conflict unless alternate bit set
// - alternate bit clear: strict priority handover
// - alternate bit set: alternate on conflict
// - bit 0 enables peripheral write buffer
// - buffered peripheral write overlaps memory access
// - bits 7,6,3,2 read zero, ignore writes
// - bit 5 reads zero, write zero
// - bit 1 resets, reads one; write one
// - select and buffer bits reset cleared
// - system bus: masters, rom, ram, bridge
// - peripheral bus carries all register accesses
// - core on system clock, peripherals on peripheral
// - system and peripheral rates set independently
// - ack highest requester; holds to the end of the bus cycle, then re-arbitrated
// - cpu yields to dma at cycle end
// - buffered write alone two cycles, then parallel
// - reset aborts bus cycle immediately
`timescale 1ns/1ns

module iba_ctrl (
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic       clk_en,
  // control register port
  input  wire logic       reg_wr,
  input  wire logic       reg_sel,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // cpu master
  input  wire logic       cpu_req,
  input  wire logic       cpu_cycle_end,
  input  wire logic       cpu_hold,
  input  wire logic [1:0] cpu_space,
  output logic            cpu_ack,
  // dma master
  input  wire logic       dma_req,
  input  wire logic       dma_cycle_end,
  input  wire logic       dma_hold,
  input  wire logic [1:0] dma_space,
  output logic            dma_ack,
  // address space selects
  output logic            rom_sel,
  output logic            ram_sel,
  output logic            peri_sel,
  // peripheral write and memory overlap
  input  wire logic       peri_wr_busy,
  input  wire logic       mem_req,
  output logic            mem_go,
  output logic            peri_wr_buffered,
  // clock enables
  output logic            sys_ce,
  output logic            per_ce
);

  logic [7:0]           arb_ctl_q;
  logic [7:0]           clk_sel_q;
  iba_pkg::iba_owner_t  own_q;
  iba_pkg::iba_owner_t  own_d;
  iba_pkg::iba_owner_t  last_q;
  logic                 acs_eff_q;
  logic                 pwbe_eff_q;
  logic [1:0]           pw_cnt_q;
  logic                 pw_buf_q;
  logic [iba_pkg::DIV_W-1:0] div_q;
  logic                 sys_ce_q;
  logic                 per_ce_q;
  logic                 boundary;
  logic                 acs_now;
  logic [1:0]           own_space;

  // low bits of the divider all zero marks a tick of 2**n
  function automatic logic div_tick(
    input logic [iba_pkg::DIV_W-1:0]     cnt,
    input logic [iba_pkg::CLK_FLD_W-1:0] n
  );
    logic [iba_pkg::DIV_W-1:0] mask;
    mask = ~({iba_pkg::DIV_W{1'b1}} << n);
    div_tick = ((cnt & mask) == '0);
  endfunction

  // control register writes
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      arb_ctl_q <= iba_pkg::ARB_CTL_RESET;
    end else if (clk_en && reg_wr &&
                 reg_sel == iba_pkg::SEL_ARB_CTL) begin
      // only select and buffer bits store; others fixed
      arb_ctl_q <= (reg_wdata & iba_pkg::ARB_CTL_WMASK)
                   | iba_pkg::ARB_CTL_ONES;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      clk_sel_q <= iba_pkg::CLK_SEL_RESET;
    end else if (clk_en && reg_wr &&
                 reg_sel == iba_pkg::SEL_CLK_SEL) begin
      clk_sel_q <= reg_wdata & iba_pkg::CLK_SEL_WMASK;
    end
  end

  // read back; bit 1 forced one, reserved bits zero
  always_comb begin
    if (reg_sel == iba_pkg::SEL_ARB_CTL) begin
      reg_rdata = (arb_ctl_q & iba_pkg::ARB_CTL_WMASK)
                  | iba_pkg::ARB_CTL_ONES;
    end else begin
      reg_rdata = clk_sel_q;
    end
  end

  // a bus cycle boundary: idle bus, or owner ends a releasable cycle
  always_comb begin
    case (own_q)
      iba_pkg::OWN_CPU: boundary = cpu_cycle_end && !cpu_hold;
      iba_pkg::OWN_DMA: boundary = dma_cycle_end && !dma_hold;
      default:          boundary = 1'b1;
    endcase
  end

  assign acs_now = arb_ctl_q[iba_pkg::BIT_ACS];

  // owner decision, taken only at a boundary
  always_comb begin
    own_d = own_q;
    if (boundary) begin
      if (cpu_req && dma_req) begin
        if (acs_now) begin
          // conflict: hand the bus to whoever did not go last; the
          // owner ending its cycle is the one that went last
          if (own_q == iba_pkg::OWN_DMA ||
              (own_q == iba_pkg::OWN_NONE && last_q == iba_pkg::OWN_DMA)) begin
            own_d = iba_pkg::OWN_CPU;
          end else begin
            own_d = iba_pkg::OWN_DMA;
          end
        end else begin
          own_d = iba_pkg::OWN_DMA;
        end
      end else if (dma_req) begin
        own_d = iba_pkg::OWN_DMA;
      end else if (cpu_req) begin
        own_d = iba_pkg::OWN_CPU;
      end else begin
        own_d = iba_pkg::OWN_NONE;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      own_q <= iba_pkg::OWN_NONE;
    end else if (clk_en) begin
      own_q <= own_d;
    end
  end

  // remembers the last master granted, for alternation
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      last_q <= iba_pkg::OWN_CPU;
    end else if (clk_en && boundary &&
                 own_q != iba_pkg::OWN_NONE) begin
      last_q <= own_q;
    end
  end

  // settings sampled at boundaries so a cycle in flight is not
  // changed midway by a register write
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      acs_eff_q  <= 1'b0;
      pwbe_eff_q <= 1'b0;
    end else if (clk_en && boundary) begin
      acs_eff_q  <= arb_ctl_q[iba_pkg::BIT_ACS];
      pwbe_eff_q <= arb_ctl_q[iba_pkg::BIT_PWBE];
    end
  end

  // ack withdrawn in the reset cycle itself
  assign cpu_ack = !reset && own_q == iba_pkg::OWN_CPU;
  assign dma_ack = !reset && own_q == iba_pkg::OWN_DMA;

  // space selects follow the current owner
  always_comb begin
    case (own_q)
      iba_pkg::OWN_CPU: own_space = cpu_space;
      iba_pkg::OWN_DMA: own_space = dma_space;
      default:          own_space = iba_pkg::SP_NONE;
    endcase
  end

  assign rom_sel  = !reset && own_space == iba_pkg::SP_ROM;
  assign ram_sel  = !reset && own_space == iba_pkg::SP_RAM;
  assign peri_sel = !reset && own_space == iba_pkg::SP_PERI;

  // counts cycles of the peripheral write in progress, saturating
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pw_cnt_q <= 2'h0;
    end else if (clk_en) begin
      if (!peri_wr_busy) begin
        pw_cnt_q <= 2'h0;
      end else if (pw_cnt_q != iba_pkg::PW_SOLO_CYCLES) begin
        pw_cnt_q <= pw_cnt_q + 2'h1;
      end
    end
  end

  // memory access waits for an unbuffered write; a buffered one
  // blocks only its first two cycles
  always_comb begin
    if (reset) begin
      mem_go = 1'b0;
    end else if (!peri_wr_busy) begin
      mem_go = mem_req;
    end else if (pwbe_eff_q &&
                 pw_cnt_q == iba_pkg::PW_SOLO_CYCLES) begin
      mem_go = mem_req;
    end else begin
      mem_go = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pw_buf_q <= 1'b0;
    end else if (clk_en) begin
      pw_buf_q <= peri_wr_busy && pwbe_eff_q;
    end
  end

  assign peri_wr_buffered = pw_buf_q;

  // clock dividers: core and peripheral rates chosen apart
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      div_q <= '0;
    end else if (clk_en) begin
      div_q <= div_q + 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sys_ce_q <= 1'b0;
      per_ce_q <= 1'b0;
    end else if (clk_en) begin
      sys_ce_q <= div_tick(div_q,
        clk_sel_q[iba_pkg::CLK_SYS_POS +: iba_pkg::CLK_FLD_W]);
      per_ce_q <= div_tick(div_q,
        clk_sel_q[iba_pkg::CLK_PER_POS +: iba_pkg::CLK_FLD_W]);
    end
  end

  assign sys_ce = sys_ce_q;
  assign per_ce = per_ce_q;

endmodule // iba_ctrl

// >>> iba_pkg.sv
// iba_pkg: constants of the internal bus arbiter and controller.
// assumes one system clock; peripheral timing derived by clock enables.
package iba_pkg;

  // register selects on the control port
  localparam logic SEL_ARB_CTL = 1'b0;
  localparam logic SEL_CLK_SEL = 1'b1;

  // bus_arbitration_control layout
  localparam int CTL_W = 8;
  localparam int BIT_PWBE = 0;
  localparam int BIT_RSV_ONE = 1;
  localparam int BIT_ACS = 4;
  localparam logic [7:0] ARB_CTL_RESET = 8'h02;
  localparam logic [7:0] ARB_CTL_WMASK = 8'h11;
  localparam logic [7:0] ARB_CTL_ONES = 8'h02;

  // clock_frequency_select layout: divide by 2**n
  localparam int CLK_SYS_POS = 0;
  localparam int CLK_PER_POS = 4;
  localparam int CLK_FLD_W = 3;
  localparam logic [7:0] CLK_SEL_RESET = 8'h00;
  localparam logic [7:0] CLK_SEL_WMASK = 8'h77;
  localparam int DIV_W = 7;

  // cycles a buffered peripheral write runs alone
  localparam logic [1:0] PW_SOLO_CYCLES = 2'h2;

  // address space codes of a bus cycle
  localparam logic [1:0] SP_NONE = 2'h0;
  localparam logic [1:0] SP_ROM = 2'h1;
  localparam logic [1:0] SP_RAM = 2'h2;
  localparam logic [1:0] SP_PERI = 2'h3;

  typedef enum logic [1:0] {
    OWN_NONE,
    OWN_CPU,
    OWN_DMA
  } iba_owner_t;

endpackage

// >>> iba_ctrl_asserts.sv
// iba_ctrl_asserts: port checks of iba_ctrl, bound at the foot.
// assumes one clock domain and a synchronous active high reset.
`timescale 1ns/1ns
module iba_ctrl_asserts (
  input wire logic       ref_clk,
  input wire logic       reset,
  input wire logic       clk_en,
  input wire logic       reg_wr,
  input wire logic       reg_sel,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       cpu_req,
  input wire logic       cpu_cycle_end,
  input wire logic       cpu_hold,
  input wire logic       cpu_ack,
  input wire logic       dma_req,
  input wire logic       dma_cycle_end,
  input wire logic       dma_hold,
  input wire logic       dma_ack,
  input wire logic       peri_wr_busy,
  input wire logic       mem_go
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic acs_q;
  logic bnd;
  assign bnd = clk_en && (!(cpu_ack || dma_ack) || (cpu_ack && cpu_cycle_end && !cpu_hold)
    || (dma_ack && dma_cycle_end && !dma_hold));
  // old value stands at the write edge, as the arbiter sees it
  always_ff @(posedge ref_clk) begin
    if (reset) acs_q <= 1'b0;
    else if (clk_en && reg_wr && !reg_sel) acs_q <= reg_wdata[4];
  end
  one_owner_a: assert property (!(cpu_ack && dma_ack))
    else $error("two owners");
  reset_idle_a: assert property (disable iff (1'b0) reset |-> !cpu_ack && !dma_ack && !mem_go)
    else $error("bus active in reset");
  fixed_bits_a: assert property (!reg_sel |-> (reg_rdata & 8'hee) == 8'h02)
    else $error("fixed bits wrong");
  ctl_write_a: assert property (clk_en && reg_wr && !reg_sel ##1 !reg_sel |->
    (reg_rdata & 8'h11) == ($past(reg_wdata) & 8'h11)) else $error("write lost");
  prio_dma_a: assert property (bnd && cpu_req && dma_req && !acs_q |=> dma_ack)
    else $error("dma lost priority");
  alt_swap_a: assert property (bnd && cpu_req && dma_req && acs_q && dma_ack |=> cpu_ack)
    else $error("no alternation");
  cpu_keeps_a: assert property (cpu_ack && !(clk_en && cpu_cycle_end && !cpu_hold) |=> cpu_ack)
    else $error("cpu lost bus mid cycle");
  solo_two_a: assert property ($rose(peri_wr_busy) |-> !mem_go ##1 (!peri_wr_busy || !mem_go))
    else $error("early overlap");
endmodule // iba_ctrl_asserts
bind iba_ctrl iba_ctrl_asserts u_chk (.*);

// >>> iba_master_model.sv
// iba_master_model: bus master with three-cycle bus cycles.
// assumes ack from iba_ctrl and a go level from the bench.
// interrupt flag read-back stays with software; no flag here
`timescale 1ns/1ns
module iba_master_model (
  input  wire logic ref_clk,
  input  wire logic reset,
  input  wire logic go,
  input  wire logic ack,
  output logic      req,
  output logic      cycle_end
);
  logic [1:0] cnt_q;
  assign req = go;
  // count restarts on each grant, so a cycle never ends before it began
  assign cycle_end = ack && cnt_q == 2'h2;
  always_ff @(posedge ref_clk) begin
    if (reset || !ack || cycle_end) cnt_q <= 2'h0;
    else cnt_q <= cnt_q + 2'h1;
  end
endmodule // iba_master_model

// >>> iba_tb.sv
// tb: register, arbitration, buffer and reset tests of iba_ctrl.
// assumes two iba_master_model instances stand for cpu and dma.
`timescale 1ns/1ns
module tb;
  logic       ref_clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_sel = 1'b0, cpu_hold = 1'b0;
  logic       cpu_go = 1'b0, dma_go = 1'b0, peri_wr_busy = 1'b0, clk_en = 1'b1;
  logic       cpu_req, cpu_cycle_end, cpu_ack, dma_req, dma_cycle_end, dma_ack, mem_go;
  logic [7:0] reg_wdata = 8'h00, reg_rdata;
  int         bad_count = 0, checked = 0;
  always #20 ref_clk = ~ref_clk;
  iba_ctrl dut (.*, .cpu_space(iba_pkg::SP_ROM), .dma_space(iba_pkg::SP_RAM), .dma_hold(1'b0),
    .mem_req(peri_wr_busy), .rom_sel(), .ram_sel(), .peri_sel(), .peri_wr_buffered(), .sys_ce(), .per_ce());
  iba_master_model u_cpu (.ref_clk, .reset, .go(cpu_go), .ack(cpu_ack), .req(cpu_req), .cycle_end(cpu_cycle_end));
  iba_master_model u_dma (.ref_clk, .reset, .go(dma_go), .ack(dma_ack), .req(dma_req), .cycle_end(dma_cycle_end));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic s, input logic [7:0] d, input logic [7:0] exp);
    @(negedge ref_clk);
    reg_sel = s;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
    chk(reg_rdata, exp);
  endtask
  task automatic owner(input logic d);
    repeat (20) if ({cpu_ack, dma_ack} !== {!d, d}) @(negedge ref_clk);
    chk({cpu_ack, dma_ack}, {!d, d});
  endtask
  // enable is latched at an idle boundary, hence the two spare cycles
  task automatic pw(input logic [7:0] ctl, input logic e);
    wr(1'b0, ctl, ctl);
    repeat (2) @(negedge ref_clk);
    peri_wr_busy = 1'b1;
    for (int i = 0; i < 3; i++) begin
      #1 chk(mem_go, e && i == 2);
      @(negedge ref_clk);
    end
    peri_wr_busy = 1'b0;
  endtask
  task automatic close_out;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge ref_clk);
    bad_count++;
    close_out;
  end
  initial begin
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    reset = 1'b0;
    chk(reg_rdata, 8'h02);
    wr(1'b1, 8'hff, 8'h77);
    wr(1'b0, 8'hff, 8'h13);
    wr(1'b0, 8'h20, 8'h02);
    clk_en = 1'b0;
    wr(1'b0, 8'h13, 8'h02);
    clk_en = 1'b1;
    $display("registers done");
    cpu_hold = 1'b1;
    cpu_go = 1'b1;
    owner(1'b0);
    dma_go = 1'b1;
    repeat (6) @(negedge ref_clk);
    owner(1'b0);
    cpu_hold = 1'b0;
    owner(1'b1);
    dma_go = 1'b0;
    owner(1'b0);
    $display("priority done");
    wr(1'b0, 8'h12, 8'h12);
    dma_go = 1'b1;
    owner(1'b1);
    owner(1'b0);
    owner(1'b1);
    cpu_go = 1'b0;
    dma_go = 1'b0;
    repeat (8) @(negedge ref_clk);
    chk({cpu_ack, dma_ack}, 8'h00);
    $display("alternate done");
    pw(8'h03, 1'b1);
    pw(8'h02, 1'b0);
    $display("buffer done");
    cpu_go = 1'b1;
    owner(1'b0);
    reset = 1'b1;
    #1 chk({cpu_ack, dma_ack}, 8'h00);
    @(negedge ref_clk);
    reset = 1'b0;
    chk(reg_rdata, 8'h02);
    $display("reset done");
    close_out;
  end
endmodule // tb
